// File: design/ncs_defs.svh
/*
  constants for the oscillator phase sync and reference divisor block.
  assumes: included by bare name, definitions only.
*/
`ifndef NCS_DEFS_SVH
`define NCS_DEFS_SVH
// ****************************************
// register offsets (byte addresses, device map)
// ****************************************
`define NCS_ADDR_RDIV 12'h217
`define NCS_ADDR_SYNC 12'h219
`define NCS_ADDR_FREQ 12'h220
// ****************************************
// reset values and fields
// ****************************************
`define NCS_RST_RDIV 16'h0000
`define NCS_RST_SYNC 8'h02
`define NCS_RST_FREQ 32'hC0000000
`define NCS_BIT_NEXT 0
`define NCS_BIT_LINK 1
`define NCS_RDIV_MAX 16'h2000
// ****************************************
// controller register map (own port)
// ****************************************
`define NCS_CADDR_CMD 4'h0
`define NCS_CADDR_DATA 4'h1
`define NCS_CADDR_STAT 4'h2
`define NCS_CADDR_RDATA 4'h3
`define NCS_CMD_WR 2'h1
`define NCS_CMD_RD 2'h2
`define NCS_CMD_OP 17:16
`define NCS_CMD_ADDR 11:0
// ****************************************
// device register select codes and pin lanes
// ****************************************
`define NCS_SEL_NONE 2'h0
`define NCS_SEL_RDIV 2'h1
`define NCS_SEL_SYNC 2'h2
`define NCS_SEL_FREQ 2'h3
`define NCS_PIN_N 2
`define NCS_PIN_REF 0
`define NCS_PIN_SYNC 1
`define NCS_PIN_IDLE 2'h2
`endif

// File: design/ncs_pkg.sv
/*
  shared types for the oscillator phase sync block.
  assumes: compiled before every other file.
*/
package ncs_pkg;
  typedef logic [11:0] ncs_addr_t;
  typedef logic [31:0] ncs_word_t;
  typedef enum logic {ncs_enc_8b10b, ncs_enc_64b66b} ncs_enc_t;
endpackage

// File: design/ncs_if.sv
/*
  carrier between the device end and the controller end: register port plus
  the timing pins sysref and sync_n.
  assumes: both ends on core_clk; the testbench instantiates it.
*/
`timescale 1ns/1ps
interface ncs_if;
  import ncs_pkg::*;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic sysref;
  logic sync_n;
  modport dev (input addr, input wdata, input wr, input rd, output rdata,
    input sysref, input sync_n);
  modport ctl (output addr, output wdata, output wr, output rd, input rdata,
    output sysref, output sync_n);
endinterface

// File: design/ncs_dev.sv
/*
  device end: reference divisor, frequency word, phase sync control and the
  phase accumulator of channel a preset 0.
  assumes: sysref and sync_n come from outside and are synchronised here;
  the multiframe boundary pulse and link encoding arrive from link logic on core_clk.
*/
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "ncs_defs.svh"
module ncs_dev (
  input wire logic core_clk,
  input wire logic srst,
  ncs_if.dev bus,
  input wire logic boundary,
  input wire ncs_pkg::ncs_enc_t enc_mode,
  output logic [31:0] phase_acc,
  output logic phase_init,
  output logic armed,
  output logic link_resync
);
  import ncs_pkg::*;
  // ****************************************
  // pin synchronisers
  // ****************************************
  // sysref idles low and sync_n high; reset loads those levels so no false edge follows
  logic [1:0] pin_in, pin_rst, pin_s, pin_p;
  assign pin_in = {bus.sync_n, bus.sysref};
  assign pin_rst = `NCS_PIN_IDLE;
  genvar gi;
  for (gi = 0; gi < `NCS_PIN_N; gi++) begin : g_pin
    logic m_q, m_d, s_q, s_d, p_q, p_d;
    always_comb begin
      m_d = pin_in[gi];
      s_d = m_q;
      p_d = s_q;
    end
    always_ff @(posedge core_clk) begin
      if (srst) begin
        m_q <= pin_rst[gi];
        s_q <= pin_rst[gi];
        p_q <= pin_rst[gi];
      end else begin
        m_q <= m_d;
        s_q <= s_d;
        p_q <= p_d;
      end
    end
    assign pin_s[gi] = s_q;
    assign pin_p[gi] = p_q;
  end
  logic sr_rise, sy_rise;
  assign sr_rise = pin_s[`NCS_PIN_REF] & ~pin_p[`NCS_PIN_REF];
  assign sy_rise = pin_s[`NCS_PIN_SYNC] & ~pin_p[`NCS_PIN_SYNC];
  // ****************************************
  // registers
  // ****************************************
  logic [15:0] rdiv_q, rdiv_d;
  logic [7:0] sync_q, sync_d;
  logic [31:0] freq_q, freq_d, rdata_q, rdata_d;
  logic zero_seen_q, zero_seen_d, armed_q, armed_d, pend_q, pend_d;
  logic init_q, init_d;
  // ****************************************
  // address decode
  // ****************************************
  // one decode for both strobes keeps the write and read maps identical
  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    if (a == `NCS_ADDR_RDIV) begin
      reg_sel = `NCS_SEL_RDIV;
    end else if (a == `NCS_ADDR_SYNC) begin
      reg_sel = `NCS_SEL_SYNC;
    end else if (a == `NCS_ADDR_FREQ) begin
      reg_sel = `NCS_SEL_FREQ;
    end else begin
      reg_sel = `NCS_SEL_NONE;
    end
  endfunction
  always_comb begin
    rdiv_d = rdiv_q;
    sync_d = sync_q;
    freq_d = freq_q;
    rdata_d = 32'h00000000;
    zero_seen_d = zero_seen_q;
    armed_d = armed_q;
    pend_d = pend_q;
    init_d = 1'b0;
    if (bus.wr) begin
      if (reg_sel(bus.addr) == `NCS_SEL_RDIV) begin
        rdiv_d = bus.wdata[15:0];
      end else if (reg_sel(bus.addr) == `NCS_SEL_SYNC) begin
        sync_d = bus.wdata[7:0];
        // a 1 written with no 0 before it does not arm
        if (!bus.wdata[`NCS_BIT_NEXT]) begin
          zero_seen_d = 1'b1;
        end else if (zero_seen_q) begin
          armed_d = 1'b1;
          zero_seen_d = 1'b0;
        end
      end else if (reg_sel(bus.addr) == `NCS_SEL_FREQ) begin
        freq_d = bus.wdata;
      end
    end
    if (bus.rd) begin
      if (reg_sel(bus.addr) == `NCS_SEL_RDIV) begin
        rdata_d = {16'h0000, rdiv_q};
      end else if (reg_sel(bus.addr) == `NCS_SEL_SYNC) begin
        rdata_d = {24'h000000, sync_q};
      end else if (reg_sel(bus.addr) == `NCS_SEL_FREQ) begin
        rdata_d = freq_q;
      end
    end
    // link-start: a boundary consumes the pending rise; a new rise in that cycle wins
    if (pend_q && boundary) begin
      pend_d = 1'b0;
      init_d = 1'b1;
    end
    if (sync_q[`NCS_BIT_LINK] && sy_rise) begin
      pend_d = 1'b1;
    end
    // arming is consumed by the first edge; later edges fall through
    if (armed_q && sr_rise) begin
      armed_d = 1'b0;
      init_d = 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdiv_q <= `NCS_RST_RDIV;
      sync_q <= `NCS_RST_SYNC;
      freq_q <= `NCS_RST_FREQ;
      rdata_q <= 32'h00000000;
      zero_seen_q <= 1'b0;
      armed_q <= 1'b0;
      pend_q <= 1'b0;
      init_q <= 1'b0;
    end else begin
      rdiv_q <= rdiv_d;
      sync_q <= sync_d;
      freq_q <= freq_d;
      rdata_q <= rdata_d;
      zero_seen_q <= zero_seen_d;
      armed_q <= armed_d;
      pend_q <= pend_d;
      init_q <= init_d;
    end
  end
  assign bus.rdata = rdata_q;
  // ****************************************
  // phase accumulator
  // ****************************************
  // with a divisor the accumulator wraps modulo rdiv*2^32 scaled; we model it as
  // a fractional remainder counter that adds one lsb every rdiv samples
  logic [31:0] acc_q, acc_d;
  logic [15:0] frac_q, frac_d;
  logic ph_q, ph_d, lr_q, lr_d;
  always_comb begin
    frac_d = frac_q;
    acc_d = acc_q + freq_q;
    if (rdiv_q != `NCS_RST_RDIV) begin
      frac_d = frac_q + 16'h0001;
      if (frac_q >= rdiv_q - 16'h0001) begin
        frac_d = 16'h0000;
        acc_d = acc_q + freq_q + 32'h00000001;
      end
    end else begin
      frac_d = 16'h0000;
    end
    if (init_q) begin
      acc_d = 32'h00000000;
      frac_d = 16'h0000;
    end
    ph_d = init_q;
    // in 64b66b sync_n never reaches the link
    lr_d = (enc_mode == ncs_enc_8b10b) & ~pin_s[`NCS_PIN_SYNC];
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_q <= 32'h00000000;
      frac_q <= 16'h0000;
      ph_q <= 1'b0;
      lr_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      frac_q <= frac_d;
      ph_q <= ph_d;
      lr_q <= lr_d;
    end
  end
  assign phase_acc = acc_q;
  assign phase_init = ph_q;
  assign armed = armed_q;
  assign link_resync = lr_q;
endmodule

// File: design/ncs_ctl.sv
/*
  controller end: drives the device register port from commands on its own small
  register port, and the sysref and sync_n pins from sysref_req and sync_n_lvl.
  assumes: same core_clk as the device; read data from the device one cycle late.
*/
`timescale 1ns/1ps
`include "ncs_defs.svh"
module ncs_ctl (
  input wire logic core_clk,
  input wire logic srst,
  ncs_if.ctl bus,
  input wire logic [3:0] c_addr,
  input wire logic [31:0] c_wdata,
  input wire logic c_wr,
  input wire logic c_rd,
  output logic [31:0] c_rdata,
  input wire logic sysref_req,
  input wire logic sync_n_lvl
);
  import ncs_pkg::*;
  // ****************************************
  // command path
  // ****************************************
  typedef enum logic [1:0] {ncs_idle, ncs_wait, ncs_take} ncs_st_t;
  ncs_st_t st_q, st_d;
  logic [31:0] cmd_q, cmd_d, data_q, data_d, got_q, got_d, crd_q, crd_d;
  logic [11:0] a_q, a_d;
  logic [31:0] w_q, w_d;
  logic wr_q, wr_d, rd_q, rd_d, sr_q, sr_d, sy_q, sy_d, busy_q, busy_d;
  always_comb begin
    st_d = st_q;
    cmd_d = cmd_q;
    data_d = data_q;
    got_d = got_q;
    crd_d = 32'h00000000;
    a_d = a_q;
    w_d = w_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    busy_d = busy_q;
    // sysref is held idle unless asked; arming order is software's job
    sr_d = sysref_req;
    sy_d = sync_n_lvl;
    if (c_wr) begin
      if (c_addr == `NCS_CADDR_DATA) begin
        data_d = c_wdata;
      end else if (c_addr == `NCS_CADDR_CMD) begin
        cmd_d = c_wdata;
      end
    end
    if (c_rd) begin
      if (c_addr == `NCS_CADDR_STAT) begin
        crd_d = {31'h00000000, busy_q};
      end else if (c_addr == `NCS_CADDR_RDATA) begin
        crd_d = got_q;
      end else if (c_addr == `NCS_CADDR_DATA) begin
        crd_d = data_q;
      end else if (c_addr == `NCS_CADDR_CMD) begin
        crd_d = cmd_q;
      end
    end
    case (st_q)
      ncs_idle: begin
        if (c_wr && c_addr == `NCS_CADDR_CMD) begin
          a_d = c_wdata[`NCS_CMD_ADDR];
          w_d = data_q;
          busy_d = 1'b1;
          // cmd bits 17:16 pick write or read; a write is one strobe and frees busy at once
          if (c_wdata[`NCS_CMD_OP] == `NCS_CMD_RD) begin
            rd_d = 1'b1;
            st_d = ncs_wait;
          end else begin
            wr_d = 1'b1;
            busy_d = 1'b0;
          end
        end
      end
      // the device answers the cycle after its strobe, so take it one edge later
      ncs_wait: begin
        st_d = ncs_take;
      end
      ncs_take: begin
        got_d = bus.rdata;
        busy_d = 1'b0;
        st_d = ncs_idle;
      end
      default: st_d = ncs_idle;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= ncs_idle;
      cmd_q <= 32'h00000000;
      data_q <= 32'h00000000;
      got_q <= 32'h00000000;
      crd_q <= 32'h00000000;
      a_q <= 12'h000;
      w_q <= 32'h00000000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      sr_q <= 1'b0;
      sy_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      data_q <= data_d;
      got_q <= got_d;
      crd_q <= crd_d;
      a_q <= a_d;
      w_q <= w_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      sr_q <= sr_d;
      sy_q <= sy_d;
      busy_q <= busy_d;
    end
  end
  assign bus.addr = a_q;
  assign bus.wdata = w_q;
  assign bus.wr = wr_q;
  assign bus.rd = rd_q;
  assign bus.sysref = sr_q;
  assign bus.sync_n = sy_q;
  assign c_rdata = crd_q;
endmodule

// File: sim/ncs_chk.sv
/* checker on the link between controller and device ends.
   assumes: placed by the bench beside the link, one clock. */
`timescale 1ns/1ps
`include "ncs_defs.svh"
module ncs_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic sysref,
  input wire logic phase_init,
  input wire logic armed
);
  // ****
  // shadow of written words
  // ****
  logic [31:0] freq_q;
  logic [31:0] freq_d;
  logic [15:0] rdiv_q;
  logic [15:0] rdiv_d;
  always_comb begin
    freq_d = freq_q;
    rdiv_d = rdiv_q;
    if (wr && addr == `NCS_ADDR_FREQ) freq_d = wdata;
    if (wr && addr == `NCS_ADDR_RDIV) rdiv_d = wdata[15:0];
  end
  always_ff @(posedge core_clk) begin
    freq_q <= srst ? `NCS_RST_FREQ : freq_d;
    rdiv_q <= srst ? `NCS_RST_RDIV : rdiv_d;
  end
  // ****
  // properties
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence ref_rise;
    !sysref ##1 sysref;
  endsequence
  // pin may be one cycle wide, so the disarm looks back over the sync stages
  idle_zero_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero when idle");
  unmapped_zero_a: assert property (rd && !(addr inside {`NCS_ADDR_RDIV,
    `NCS_ADDR_SYNC, `NCS_ADDR_FREQ}) |=> rdata == 32'h0) else $error("unmapped read not zero");
  freq_rdback_a: assert property (rd && addr == `NCS_ADDR_FREQ |=> rdata == freq_q)
    else $error("frequency word readback wrong");
  rdiv_rdback_a: assert property (rd && addr == `NCS_ADDR_RDIV |=>
    rdata[15:0] == rdiv_q) else $error("divisor readback wrong");
  arm_cause_a: assert property ($rose(armed) |->
    $past(wr && addr == `NCS_ADDR_SYNC && wdata[`NCS_BIT_NEXT]))
    else $error("armed without a write of one");
  arm_fire_a: assert property (ref_rise ##0 armed |-> ##[1:6] phase_init)
    else $error("armed edge gave no phase init");
  init_pulse_a: assert property (phase_init |=> !phase_init)
    else $error("phase init longer than one cycle");
  disarm_cause_a: assert property ($fell(armed) |-> $past(sysref, 2) || $past(sysref, 3)
    || $past(sysref, 4) || $past(sysref, 5) || $past(wr)) else $error("armed dropped without cause");
endmodule

// File: sim/nco_phase_sync_and_divisor_test.sv
/* self-checking bench: controller and device ends joined by the link.
   assumes: design files compiled first; one 40 MHz clock. */
`timescale 1ns/1ps
`include "ncs_defs.svh"
module nco_phase_sync_and_divisor_test;
  import ncs_pkg::*;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} ncs_row_t;
  logic core_clk, srst, c_wr, c_rd, sysref_req, sync_n_lvl, boundary, g;
  logic phase_init, armed, link_resync;
  logic [3:0] c_addr;
  logic [31:0] c_wdata, c_rdata, phase_acc, v, p;
  ncs_enc_t enc_mode;
  int n_fail, check_count;
  ncs_row_t rows [5];
  ncs_if link ();
  ncs_dev i_ncs_dev (.core_clk(core_clk), .srst(srst), .bus(link), .boundary(boundary),
    .enc_mode(enc_mode), .phase_acc(phase_acc), .phase_init(phase_init), .armed(armed),
    .link_resync(link_resync));
  ncs_ctl i_ncs_ctl (.core_clk(core_clk), .srst(srst), .bus(link), .c_addr(c_addr),
    .c_wdata(c_wdata), .c_wr(c_wr), .c_rd(c_rd), .c_rdata(c_rdata), .sysref_req(sysref_req),
    .sync_n_lvl(sync_n_lvl));
  ncs_chk i_ncs_chk (.core_clk(core_clk), .srst(srst), .addr(link.addr), .wdata(link.wdata),
    .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .sysref(link.sysref),
    .phase_init(phase_init), .armed(armed));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cw(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    c_addr <= a;
    c_wdata <= d;
    c_wr <= 1'b1;
    @(posedge core_clk);
    c_wr <= 1'b0;
  endtask
  task automatic cr(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    c_addr <= a;
    c_rd <= 1'b1;
    @(posedge core_clk);
    c_rd <= 1'b0;
    #1 d = c_rdata;
  endtask
  // busy is polled under a bound so a stuck command cannot hang the run
  task automatic dev_op(input logic [1:0] op, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    logic [31:0] s;
    cw(`NCS_CADDR_DATA, d);
    cw(`NCS_CADDR_CMD, {14'h0000, op, 4'h0, a});
    repeat (3) @(posedge core_clk);
    s = 32'h1;
    for (int i = 0; i < 20 && s[0] !== 1'b0; i++) cr(`NCS_CADDR_STAT, s);
    chk({31'h0, s[0]}, 32'h0);
    cr(`NCS_CADDR_RDATA, r);
  endtask
  task automatic wait_init(input int n);
    g = 1'b0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (phase_init === 1'b1 && !g) begin
        g = 1'b1;
        p = phase_acc;
      end
    end
  endtask
  task automatic pulse_ref;
    @(posedge core_clk);
    sysref_req <= 1'b1;
    @(posedge core_clk);
    sysref_req <= 1'b0;
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****
  // stimulus
  // ****
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (4000) @(posedge core_clk);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    {srst, c_addr, c_wdata, c_wr, c_rd, sysref_req, boundary} = {1'b1, 40'h0};
    sync_n_lvl = 1'b1;
    enc_mode = ncs_enc_8b10b;
    // the divisor row keeps to an integer value no larger than 8192
    rows = '{'{`NCS_ADDR_RDIV, 32'h2000, 32'h2000},
      '{`NCS_ADDR_FREQ, 32'h12345678, 32'h12345678},
      '{`NCS_ADDR_FREQ, 32'hFFFFFFFF, 32'hFFFFFFFF}, '{`NCS_ADDR_SYNC, 32'h2, 32'h2},
      '{12'h218, 32'h55, 32'h0}};
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    foreach (rows[i]) begin
      dev_op(`NCS_CMD_WR, rows[i].a, rows[i].d, v);
      dev_op(`NCS_CMD_RD, rows[i].a, 32'h0, v);
      chk(v, rows[i].e);
    end
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    dev_op(`NCS_CMD_RD, `NCS_ADDR_RDIV, 32'h0, v);
    chk(v, 32'h0);
    dev_op(`NCS_CMD_RD, `NCS_ADDR_SYNC, 32'h0, v);
    chk(v, 32'h2);
    dev_op(`NCS_CMD_RD, `NCS_ADDR_FREQ, 32'h0, v);
    chk(v, 32'hC0000000);
    @(posedge core_clk);
    #1 p = phase_acc;
    @(posedge core_clk);
    #1 chk(phase_acc - p, 32'hC0000000);
    dev_op(`NCS_CMD_WR, `NCS_ADDR_SYNC, 32'h0, v);
    dev_op(`NCS_CMD_WR, `NCS_ADDR_SYNC, 32'h1, v);
    chk({31'h0, armed}, 32'h1);
    pulse_ref;
    wait_init(10);
    chk({31'h0, g}, 32'h1);
    chk(p, 32'h0);
    chk({31'h0, armed}, 32'h0);
    pulse_ref;
    wait_init(10);
    chk({31'h0, g}, 32'h0);
    dev_op(`NCS_CMD_WR, `NCS_ADDR_SYNC, 32'h1, v);
    chk({31'h0, armed}, 32'h0);
    dev_op(`NCS_CMD_WR, `NCS_ADDR_SYNC, 32'h2, v);
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      enc_mode <= ncs_enc_t'(k);
      sync_n_lvl <= 1'b0;
      repeat (6) @(posedge core_clk);
      #1 chk({31'h0, link_resync}, {31'h0, k == 0});
      @(posedge core_clk);
      sync_n_lvl <= 1'b1;
      repeat (6) @(posedge core_clk);
      boundary <= 1'b1;
      @(posedge core_clk);
      boundary <= 1'b0;
      wait_init(4);
      chk({31'h0, g}, 32'h1);
      chk({31'h0, link_resync}, 32'h0);
    end
    dev_op(`NCS_CMD_WR, `NCS_ADDR_RDIV, 32'h1, v);
    @(posedge core_clk);
    #1 p = phase_acc;
    @(posedge core_clk);
    #1 chk(phase_acc - p, 32'hC0000001);
    tally_and_finish;
  end
endmodule
